// ===== src/fcc_pkg.sv
// Constants, register map and carrier types of the four-channel capture/compare timer.
// Assumes an APB slave with 32-bit data; each register sits in the low bits of one word.
package fcc_pkg;

	// ****************************************
	// Sizes
	// ****************************************
	localparam int NUM_CHAN  = 4;
	localparam int CNT_W     = 16;
	localparam int PRE_W     = 7;
	localparam int ADDR_W    = 12;
	localparam int DIE_DIV_W = 2;

	// ****************************************
	// Register indices (byte address = index * 4)
	// ****************************************
	localparam logic [7:0] IDX_CHAN_FUNC = 8'h20;
	localparam logic [7:0] IDX_COUNTER   = 8'h24;
	localparam logic [7:0] IDX_SYS_CTRL1 = 8'h26;
	localparam logic [7:0] IDX_ACTION    = 8'h28;
	localparam logic [7:0] IDX_EDGE      = 8'h29;
	localparam logic [7:0] IDX_IRQ_EN    = 8'h2A;
	localparam logic [7:0] IDX_SYS_CTRL2 = 8'h2B;
	localparam logic [7:0] IDX_FLAGS1    = 8'h2C;
	localparam logic [7:0] IDX_FLAGS2    = 8'h2D;
	localparam logic [7:0] IDX_VAL0      = 8'h2E;
	localparam logic [7:0] IDX_VAL_STEP  = 8'h02;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int SYS1_SRC_SEL_BIT  = 0;
	localparam int SYS1_FAST_CLR_BIT = 4;
	localparam int SYS1_ENABLE_BIT   = 7;
	localparam int SYS2_OVF_IE_BIT   = 7;
	localparam int SYS2_CRE_BIT      = 3;
	localparam int SYS2_PRE_LSB      = 0;
	localparam int FLG2_OVF_BIT      = 7;

	// ****************************************
	// Reset values and counter maximum
	// ****************************************
	localparam logic [7:0]       RST_REG8 = 8'h00;
	localparam logic [CNT_W-1:0] RST_CNT  = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;

	// ****************************************
	// Output action codes (mode bit, level bit)
	// ****************************************
	typedef enum logic [1:0] {
		FCC_ACT_OFF    = 2'h0,
		FCC_ACT_TOGGLE = 2'h1,
		FCC_ACT_CLEAR  = 2'h2,
		FCC_ACT_SET    = 2'h3
	} fcc_action_t;

	typedef struct packed {
		logic        is_cmp;
		fcc_action_t action;
		logic [1:0]  edge_sel;
	} fcc_chan_cfg_t;

	typedef struct packed {
		logic [NUM_CHAN-1:0] level;
		logic [NUM_CHAN-1:0] oe;
	} fcc_pin_out_t;

endpackage : fcc_pkg

// ===== src/fcc_prescaler.sv
// Power-of-two prescaler that switches divisor only at the all-zero point or while stopped.
// Assumes src_tick is a one-cycle pulse on pclk.
`timescale 1ns/1ps
module fcc_prescaler
	import fcc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        run,
	input  wire logic        src_tick,
	input  wire logic [2:0]  sel_req,
	output logic             tick,
	output logic [2:0]       sel_active
);
	import fcc_pkg::*;

	logic [PRE_W-1:0] stage_r;
	logic [2:0]       sel_r;
	logic [PRE_W-1:0] mask;

	assign mask       = PRE_W'((8'h01 << sel_r) - 8'h01);
	// Divide by two to the power of the active code
	assign tick       = run && src_tick && ((stage_r & mask) == mask);
	assign sel_active = sel_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_r <= '0;
		end else if (clk_en && run && src_tick) begin
			stage_r <= stage_r + PRE_W'(1);
		end
	end

	// Switch only as all stages roll to zero or while stopped, so no short period appears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_r <= 3'h0;
		end else if (clk_en && ((run && src_tick && (&stage_r)) || !run)) begin
			sel_r <= sel_req;
		end
	end

endmodule : fcc_prescaler

// ===== src/fcc_channel.sv
// One timer channel: capture edge detector and compare output action.
// Assumes pin_lvl is already synchronised to pclk.
`timescale 1ns/1ps
module fcc_channel
	import fcc_pkg::*;
(
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             clk_en,
	input  wire logic             pin_lvl,
	input  wire logic             tick,
	input  wire logic [CNT_W-1:0] cnt,
	input  wire logic [CNT_W-1:0] cmp_val,
	input  fcc_chan_cfg_t         cfg,
	output logic                  match,
	output logic                  cap_evt,
	output logic                  out_lvl
);
	import fcc_pkg::*;

	logic prev_r;
	logic out_r;
	logic rise;
	logic fall;

	assign rise    = pin_lvl & ~prev_r;
	assign fall    = ~pin_lvl & prev_r;
	assign cap_evt = !cfg.is_cmp
		&& ((cfg.edge_sel[0] && rise) || (cfg.edge_sel[1] && fall));
	assign match   = cfg.is_cmp && tick && (cnt == cmp_val);
	assign out_lvl = out_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= 1'b0;
		end else if (clk_en) begin
			prev_r <= pin_lvl;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r <= 1'b0;
		end else if (clk_en && match) begin
			case (cfg.action)
				FCC_ACT_TOGGLE: out_r <= ~out_r;
				FCC_ACT_CLEAR:  out_r <= 1'b0;
				FCC_ACT_SET:    out_r <= 1'b1;
				default:        out_r <= out_r;
			endcase
		end
	end

endmodule : fcc_channel

// ===== src/fcc_top.sv
// Four-channel 16-bit capture/compare timer with APB register access.
// Assumes timer pins and both source clocks arrive asynchronously to pclk.
//
// Notes on behaviour
// - Two-bit action per channel: off, toggle, clear or set on compare.
// - Nonzero action code makes the channel pin an output driven by compare.
// - Edge select: off, rising only, falling only, or either edge captures.
// - Per-channel enable lets its event flag raise the interrupt request.
// - Overflow enable lets a set overflow flag raise the interrupt request.
// - With counter reset enabled, channel 3 compare resets counter to zero.
// - Counter reset enabled and channel 3 value zero holds counter at zero.
// - Counter reset at all-ones match wraps to zero without overflow flag.
// - New prescale choice takes effect only when all prescale stages are zero or the timer is stopped.
// - Prescaler divides source clock by two to the power of the code.
// - Source clock is die link clock over four or auxiliary low clock.
// - Capture or compare event sets that channel's event flag.
// - Writing one clears a channel flag; writing zero leaves it.
// - Fast clear: capture value read or compare value write clears flag.
// - Counter wrap from all ones to zero sets the overflow flag.
// - Writing one clears overflow; fast clear makes any counter access clear it.
// - Main counter is 16 bits, counting up on each prescaled tick.
// - Selected capture edge latches the counter into the channel value.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module fcc_top
	import fcc_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              pclken,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic [NUM_CHAN-1:0] channel_pin_in,
	output logic [NUM_CHAN-1:0]    channel_pin_out,
	output logic [NUM_CHAN-1:0]    channel_pin_oe,
	input  wire logic              die_link_clock,
	input  wire logic              aux_low_freq_clock,
	output logic                   irq_req
);
	import fcc_pkg::*;

	// ****************************************
	// Decoding helpers
	// ****************************************
	function automatic logic [7:0] addr_idx(input logic [ADDR_W-1:0] a);
		addr_idx = a[9:2];
	endfunction : addr_idx

	function automatic logic is_val_idx(input logic [7:0] idx, input int ch);
		is_val_idx = (idx == (IDX_VAL0 + 8'(ch * 2)));
	endfunction : is_val_idx

	// ****************************************
	// Registers and state
	// ****************************************
	logic [NUM_CHAN-1:0] chan_func_r;
	logic [7:0]          sys1_r;
	logic [7:0]          action_r;
	logic [7:0]          edge_r;
	logic [NUM_CHAN-1:0] irq_en_r;
	logic [7:0]          sys2_r;
	logic [NUM_CHAN-1:0] chan_flag_r;
	logic                overflow_flag_r;
	logic [CNT_W-1:0]    cnt_r;
	logic [CNT_W-1:0]    val_r [NUM_CHAN];
	logic [31:0]         prdata_r;
	logic                pslverr_r;

	logic [NUM_CHAN+1:0] sync1_r;
	logic [NUM_CHAN+1:0] sync2_r;
	logic                die_prev_r;
	logic                aux_prev_r;
	logic [DIE_DIV_W-1:0] die_div_r;

	logic [7:0]          idx;
	logic                access;
	logic                wr_acc;
	logic                rd_acc;
	logic                setup;
	logic                mapped;
	logic [31:0]         rd_mux;
	logic                src_tick;
	logic                tick;
	logic [NUM_CHAN-1:0] match;
	logic [NUM_CHAN-1:0] cap_evt;
	logic [NUM_CHAN-1:0] out_lvl;
	logic [NUM_CHAN-1:0] flag_clr;
	logic                ovf_clr;
	logic                cnt_reset;
	logic                run;
	fcc_chan_cfg_t       cfg [NUM_CHAN];

	assign idx    = addr_idx(paddr);
	assign setup  = pclken && psel && !penable;
	assign access = pclken && psel && penable;
	assign wr_acc = access && pwrite && !pslverr_r;
	assign rd_acc = access && !pwrite && !pslverr_r;
	assign run    = sys1_r[SYS1_ENABLE_BIT];

	// ****************************************
	// APB slave
	// ****************************************
	// Read data and error latched in setup, so outputs come from flops
	assign pready  = pclken;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;

	always_comb begin
		mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
		rd_mux = 32'h0000_0000;
		case (idx)
			IDX_CHAN_FUNC: rd_mux = {28'h0, chan_func_r};
			IDX_COUNTER:   rd_mux = {16'h0, cnt_r};
			IDX_SYS_CTRL1: rd_mux = {24'h0, sys1_r};
			IDX_ACTION:    rd_mux = {24'h0, action_r};
			IDX_EDGE:      rd_mux = {24'h0, edge_r};
			IDX_IRQ_EN:    rd_mux = {28'h0, irq_en_r};
			IDX_SYS_CTRL2: rd_mux = {24'h0, sys2_r};
			IDX_FLAGS1:    rd_mux = {28'h0, chan_flag_r};
			IDX_FLAGS2:    rd_mux = {24'h0, overflow_flag_r, 7'h00};
			default: begin
				mapped = 1'b0;
				for (int c = 0; c < NUM_CHAN; c++) begin
					if (is_val_idx(idx, c)) begin
						rd_mux = {16'h0, val_r[c]};
						mapped = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
					end
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			prdata_r  <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_r <= !mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_func_r <= '0;
			sys1_r      <= RST_REG8;
			action_r    <= RST_REG8;
			edge_r      <= RST_REG8;
			irq_en_r    <= '0;
			sys2_r      <= RST_REG8;
		end else if (wr_acc) begin
			case (idx)
				IDX_CHAN_FUNC: chan_func_r <= pwdata[NUM_CHAN-1:0];
				IDX_SYS_CTRL1: sys1_r      <= pwdata[7:0] & 8'h91;
				IDX_ACTION:    action_r    <= pwdata[7:0];
				IDX_EDGE:      edge_r      <= pwdata[7:0];
				IDX_IRQ_EN:    irq_en_r    <= pwdata[NUM_CHAN-1:0];
				IDX_SYS_CTRL2: sys2_r      <= pwdata[7:0] & 8'h8F;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Pin and source clock synchronisers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else if (pclken) begin
			sync1_r <= {aux_low_freq_clock, die_link_clock, channel_pin_in};
			sync2_r <= sync1_r;
		end
	end

	// Source clocks are sampled, so they must run well below pclk / 2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			die_prev_r <= 1'b0;
			aux_prev_r <= 1'b0;
			die_div_r  <= '0;
		end else if (pclken) begin
			die_prev_r <= sync2_r[NUM_CHAN];
			aux_prev_r <= sync2_r[NUM_CHAN+1];
			if (sync2_r[NUM_CHAN] && !die_prev_r) begin
				die_div_r <= die_div_r + DIE_DIV_W'(1);
			end
		end
	end

	assign src_tick = sys1_r[SYS1_SRC_SEL_BIT]
		? (sync2_r[NUM_CHAN+1] && !aux_prev_r)
		: (sync2_r[NUM_CHAN] && !die_prev_r && (&die_div_r));

	fcc_prescaler u_pre (
		.pclk       (pclk),
		.presetn    (presetn),
		.clk_en     (pclken),
		.run        (run),
		.src_tick   (src_tick),
		.sel_req    (sys2_r[SYS2_PRE_LSB +: 3]),
		.tick       (tick),
		.sel_active ()
	);

	// ****************************************
	// Channels
	// ****************************************
	generate
		for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
			assign cfg[g] = '{is_cmp:   chan_func_r[g],
			                  action:   fcc_action_t'(action_r[2*g +: 2]),
			                  edge_sel: edge_r[2*g +: 2]};

			fcc_channel u_chan (
				.pclk    (pclk),
				.presetn (presetn),
				.clk_en  (pclken),
				.pin_lvl (sync2_r[g]),
				.tick    (tick),
				.cnt     (cnt_r),
				.cmp_val (val_r[g]),
				.cfg     (cfg[g]),
				.match   (match[g]),
				.cap_evt (cap_evt[g]),
				.out_lvl (out_lvl[g])
			);

			assign channel_pin_out[g] = out_lvl[g];
			assign channel_pin_oe[g]  = |action_r[2*g +: 2];

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					val_r[g] <= RST_CNT;
				end else if (pclken) begin
					if (cap_evt[g]) begin
						val_r[g] <= cnt_r;
					end else if (wr_acc && chan_func_r[g] && is_val_idx(idx, g)) begin
						val_r[g] <= pwdata[CNT_W-1:0];
					end
				end
			end

			// Write one clears; fast clear on capture read or compare write
			assign flag_clr[g] = (wr_acc && (idx == IDX_FLAGS1) && pwdata[g])
				|| (sys1_r[SYS1_FAST_CLR_BIT] && access && !pslverr_r
				    && is_val_idx(idx, g) && (pwrite == chan_func_r[g]));
		end
	endgenerate

	// ****************************************
	// Main counter and flags
	// ****************************************
	assign cnt_reset = sys2_r[SYS2_CRE_BIT] && match[NUM_CHAN-1];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= RST_CNT;
		end else if (pclken && tick) begin
			cnt_r <= cnt_reset ? RST_CNT : cnt_r + CNT_W'(1);
		end
	end

	// Errored transfers never clear a flag
	assign ovf_clr = (wr_acc && (idx == IDX_FLAGS2) && pwdata[FLG2_OVF_BIT])
		|| (sys1_r[SYS1_FAST_CLR_BIT] && access && !pslverr_r
		    && (idx == IDX_COUNTER));

	// Hardware set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_flag_r     <= '0;
			overflow_flag_r <= 1'b0;
		end else if (pclken) begin
			chan_flag_r <= (chan_flag_r & ~flag_clr) | match | cap_evt;
			if (tick && (cnt_r == CNT_MAX) && !cnt_reset) begin
				overflow_flag_r <= 1'b1;
			end else if (ovf_clr) begin
				overflow_flag_r <= 1'b0;
			end
		end
	end


	// ****************************************
	// Interrupt request
	// ****************************************
	// Level request; stays high until software clears the flag
	assign irq_req = (|(chan_flag_r & irq_en_r))
		|| (overflow_flag_r && sys2_r[SYS2_OVF_IE_BIT]);

endmodule : fcc_top

// ===== tb/fcc_chk.sv
// Port-level checker for the capture/compare timer top.
// Assumes single pclk domain; shadows a few registers from APB writes.
`timescale 1ns/1ps
module fcc_chk (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         pclken,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [fcc_pkg::ADDR_W-1:0]   paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [31:0]                  prdata,
	input wire logic [fcc_pkg::NUM_CHAN-1:0] channel_pin_out,
	input wire logic [fcc_pkg::NUM_CHAN-1:0] channel_pin_oe,
	input wire logic                         irq_req
);
	import fcc_pkg::*;

	localparam logic [ADDR_W-1:0] A_ACT = {2'b00, IDX_ACTION, 2'b00};
	localparam logic [ADDR_W-1:0] A_IEN = {2'b00, IDX_IRQ_EN, 2'b00};
	localparam logic [ADDR_W-1:0] A_SY2 = {2'b00, IDX_SYS_CTRL2, 2'b00};
	localparam logic [ADDR_W-1:0] A_FLG = {2'b00, IDX_FLAGS1, 2'b00};
	localparam logic [ADDR_W-1:0] A_CNT = {2'b00, IDX_COUNTER, 2'b00};

	logic [7:0] act_r;
	logic [3:0] ien_r;
	logic       ovf_ie_r;
	wire        wr_acc = psel && penable && pwrite && pclken;

	// ****************************************
	// Register shadows, committed at the access edge
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_r    <= 8'h00;
			ien_r    <= 4'h0;
			ovf_ie_r <= 1'b0;
		end else if (wr_acc) begin
			if (paddr == A_ACT) act_r <= pwdata[7:0];
			if (paddr == A_IEN) ien_r <= pwdata[3:0];
			if (paddr == A_SY2) ovf_ie_r <= pwdata[7];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence rd_acc(logic [ADDR_W-1:0] a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence set_held;
		act_r[1:0] == 2'h3 ##1 act_r[1:0] == 2'h3;
	endsequence
	sequence clr_held;
		act_r[3:2] == 2'h2 ##1 act_r[3:2] == 2'h2;
	endsequence

	// ****************************************
	// Assertions
	// ****************************************
	chk_oe_action: assert property (channel_pin_oe ==
		{|act_r[7:6], |act_r[5:4], |act_r[3:2], |act_r[1:0]})
		else $error("pin enable disagrees with action code");
	chk_oe_steady: assert property (!(wr_acc && paddr == A_ACT) |=>
		$stable(channel_pin_oe)) else $error("pin enable moved without write");
	chk_set_nofall: assert property (set_held |-> !$fell(channel_pin_out[0]))
		else $error("set action drove pin low");
	chk_clr_norise: assert property (clr_held |-> !$rose(channel_pin_out[1]))
		else $error("clear action drove pin high");
	chk_irq_gated: assert property (irq_req |-> (ien_r != 4'h0 || ovf_ie_r))
		else $error("interrupt without any enable");
	chk_ien_upper: assert property (rd_acc(A_IEN) |-> prdata[7:4] == 4'h0)
		else $error("enable upper bits not zero");
	chk_flg_upper: assert property (rd_acc(A_FLG) |-> prdata[7:4] == 4'h0)
		else $error("flag upper bits not zero");
	chk_cnt_width: assert property (rd_acc(A_CNT) |-> prdata[31:16] == 16'h0)
		else $error("counter wider than 16 bits");
endmodule : fcc_chk

bind fcc_top fcc_chk u_fcc_chk (.pclk(pclk), .presetn(presetn), .pclken(pclken),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
	.irq_req(irq_req));

// ===== tb/fcc_pins.sv
// Far-side model: timer pin levels and the two source clocks.
// Assumes the bench sets pin levels; clocks run free.
`timescale 1ns/1ps
module fcc_pins (
	input  wire logic [3:0] pin_lvl,
	output logic      [3:0] channel_pin_in,
	output logic            die_link_clock,
	output logic            aux_low_freq_clock
);
	initial die_link_clock = 1'b0;
	initial aux_low_freq_clock = 1'b0;
	// Half periods of 4 and 8 pclk keep both well under pclk/2
	always #40 die_link_clock = ~die_link_clock;
	always #80 aux_low_freq_clock = ~aux_low_freq_clock;
	assign channel_pin_in = pin_lvl;
endmodule : fcc_pins

// ===== tb/tb.sv
// Self-checking bench for the capture/compare timer.
// Assumes fcc_pins supplies source clocks and pin levels.
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, a); end end
module tb;
	import fcc_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              pclken = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0]       pwdata = '0;
	logic [31:0]       prdata;
	logic [31:0]       rd;
	logic              pready, pslverr, err, irq_req, die_clk, aux_clk;
	logic [3:0]        pin_lvl = 4'h0;
	logic [3:0]        pin_in, pin_out, pin_oe;
	int                bad_count = 0;
	int                check_count = 0;
	localparam logic [7:0] TC3 = IDX_VAL0 + 8'h3 * IDX_VAL_STEP;

	fcc_top u_fcc_top (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .channel_pin_in(pin_in),
		.channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .die_link_clock(die_clk),
		.aux_low_freq_clock(aux_clk), .irq_req(irq_req));
	fcc_pins u_fcc_pins (.pin_lvl(pin_lvl), .channel_pin_in(pin_in),
		.die_link_clock(die_clk), .aux_low_freq_clock(aux_clk));

	always #5 pclk = ~pclk;

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : results

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			bad_count++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	task automatic wait_flags(input logic [3:0] m);
		int n;
		n = 0;
		do begin
			apb(1'b0, IDX_FLAGS1, 32'h0);
			n++;
		end while ((rd[3:0] & m) !== m && n < 500);
		if ((rd[3:0] & m) !== m) begin
			bad_count++;
			results();
		end
	endtask : wait_flags

	task automatic t_reset();
		apb(1'b0, IDX_ACTION, 32'h0);
		`CHK("action_rst", 32'h0, rd)
		apb(1'b0, IDX_IRQ_EN, 32'h0);
		`CHK("irq_en_rst", 32'h0, rd)
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("flags_rst", 32'h0, rd)
		apb(1'b0, 8'h3F, 32'h0);
		`CHK("unmapped_err", 1'b1, err)
		apb(1'b1, IDX_EDGE, 32'hA5);
		apb(1'b0, IDX_EDGE, 32'h0);
		`CHK("edge_rw", 32'hA5, rd)
		$display("test reset done");
	endtask : t_reset

	task automatic t_compare();
		apb(1'b1, IDX_CHAN_FUNC, 32'hF);
		for (int i = 0; i < 3; i++) apb(1'b1, IDX_VAL0 + i[7:0] * IDX_VAL_STEP, 32'h3);
		apb(1'b1, TC3, 32'h0);
		// No mask register here, so the action code owns the pins
		apb(1'b1, IDX_ACTION, 32'h1B);
		`CHK("pin_oe", 4'h7, pin_oe)
		apb(1'b1, IDX_SYS_CTRL2, 32'h08);
		apb(1'b1, IDX_SYS_CTRL1, 32'h80);
		repeat (200) @(posedge pclk);
		apb(1'b0, IDX_COUNTER, 32'h0);
		`CHK("cnt_held", 16'h0, rd[15:0])
		apb(1'b1, TC3, 32'h5);
		wait_flags(4'hF);
		`CHK("pins_out", 3'b101, pin_out[2:0])
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, IDX_COUNTER, 32'h0);
			`CHK("cnt_wrap", 1'b1, rd[15:0] <= 16'h5)
		end
		$display("test compare done");
	endtask : t_compare

	task automatic t_irq();
		apb(1'b1, IDX_SYS_CTRL1, 32'h0);
		`CHK("irq_off", 1'b0, irq_req)
		apb(1'b1, IDX_IRQ_EN, 32'h2);
		`CHK("irq_on", 1'b1, irq_req)
		apb(1'b1, IDX_FLAGS1, 32'h0);
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("w0_keeps", 32'hF, rd)
		apb(1'b1, IDX_FLAGS1, 32'h2);
		`CHK("irq_cleared", 1'b0, irq_req)
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("w1_clears", 32'hD, rd)
		apb(1'b1, IDX_IRQ_EN, 32'hFF);
		apb(1'b0, IDX_IRQ_EN, 32'h0);
		`CHK("ien_upper", 32'hF, rd)
		`CHK("irq_other", 1'b1, irq_req)
		$display("test irq done");
	endtask : t_irq

	task automatic t_capture();
		apb(1'b1, IDX_CHAN_FUNC, 32'hE);
		apb(1'b1, IDX_EDGE, 32'h1);
		apb(1'b1, IDX_FLAGS1, 32'hF);
		apb(1'b1, IDX_SYS_CTRL1, 32'h80);
		pin_lvl <= 4'h1;
		repeat (10) @(posedge pclk);
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("cap_rise", 1'b1, rd[0])
		apb(1'b1, IDX_SYS_CTRL1, 32'h90);
		apb(1'b0, IDX_VAL0, 32'h0);
		`CHK("cap_value", 1'b1, rd[15:0] <= 16'h5)
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("fast_clear", 1'b0, rd[0])
		apb(1'b1, IDX_FLAGS1, 32'h1);
		pin_lvl <= 4'h0;
		repeat (10) @(posedge pclk);
		apb(1'b0, IDX_FLAGS1, 32'h0);
		`CHK("no_cap_fall", 1'b0, rd[0])
		$display("test capture done");
	endtask : t_capture

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_compare();
		t_irq();
		t_capture();
		results();
	end
endmodule : tb
